// ---- hdl/annp_regs.sv ----
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module annp_regs (
   // Clock and reset.
   input wire logic I_SYS_CLK,
   input wire logic I_RST_N,
   // Wishbone slave.
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [6:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   // Autonegotiation engine status.
   input wire logic I_LP_AN_ABLE,
   input wire logic I_LP_NP_ABLE,
   input wire logic I_PD_FAULT,
   input wire logic I_PAGE_RX,
   input wire logic [15:0] I_RX_PAGE,
   input wire logic I_TX_TOGGLE,
   // Transmit next page to the engine.
   output logic [15:0] O_TX_PAGE,
   output logic O_TX_PAGE_WR,
   // Indirect device space.
   output logic [4:0] O_IND_DEV,
   output logic [15:0] O_IND_ADDR,
   output logic O_IND_WR,
   output logic O_IND_RD,
   output logic [15:0] O_IND_WDATA,
   input wire logic [15:0] I_IND_RDATA,
   // Interrupt.
   output logic O_IRQ
);
   // ------------------------------------------------------------
   // Bus decode.
   // ------------------------------------------------------------
   logic fire;
   logic wr;
   logic rd;
   logic [4:0] idx;
   logic lo_en;
   logic hi_en;

   annp_wb_slave u_wb (
      .i_clk(I_SYS_CLK),
      .i_rst_n(I_RST_N),
      .i_cyc(I_WB_CYC),
      .i_stb(I_WB_STB),
      .o_ack(O_WB_ACK),
      .o_fire(fire)
   );

   // Word-aligned index; writes take effect on the acked cycle only.
   assign idx = I_WB_ADR[6:2];
   assign wr = fire && I_WB_WE;
   assign rd = fire && !I_WB_WE;
   assign lo_en = I_WB_SEL[0];
   assign hi_en = I_WB_SEL[1];

   // Merge the written low half word by byte lanes.
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic lo, input logic hi);
      merge16 = {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
   endfunction

   // ------------------------------------------------------------
   // Latched events: expansion flags and interrupt status.
   // ------------------------------------------------------------
   logic [1:0] exp_flag;
   logic [1:0] int_stat;
   logic [1:0] ev;
   logic exp_rd;
   logic stat_rd;

   assign ev = {I_PD_FAULT, I_PAGE_RX};
   assign exp_rd = rd && (idx == annp_pkg::IDX_EXP);
   assign stat_rd = rd && (idx == annp_pkg::IDX_INT_STAT);

   annp_latch #(.W(2)) u_exp (
      .i_clk(I_SYS_CLK),
      .i_rst_n(I_RST_N),
      .i_set(ev),
      .i_clr(exp_rd),
      .o_flag(exp_flag)
   );

   // Interrupt status mirrors the same events, cleared by its own read.
   annp_latch #(.W(annp_pkg::INT_W)) u_int (
      .i_clk(I_SYS_CLK),
      .i_rst_n(I_RST_N),
      .i_set(ev),
      .i_clr(stat_rd),
      .o_flag(int_stat)
   );

   // ------------------------------------------------------------
   // Writable registers.
   // ------------------------------------------------------------
   logic [15:0] tx_reg;
   logic [15:0] tx_next;
   logic [1:0] fn_reg;
   logic [1:0] fn_next;
   logic [4:0] dev_reg;
   logic [4:0] dev_next;
   logic [15:0] addr_reg;
   logic [15:0] addr_next;
   logic [1:0] mask_reg;
   logic [1:0] mask_next;
   logic txwr_reg;
   logic txwr_next;
   logic indwr_reg;
   logic indwr_next;
   logic [15:0] wdata_reg;
   logic [15:0] wdata_next;
   logic [15:0] ctl_new;
   logic [15:0] tx_new;

   // Next values of the writable registers and the write strobes.
   always_comb begin
      tx_next = tx_reg;
      fn_next = fn_reg;
      dev_next = dev_reg;
      addr_next = addr_reg;
      mask_next = mask_reg;
      txwr_next = 1'b0;
      indwr_next = 1'b0;
      wdata_next = wdata_reg;
      ctl_new = merge16({fn_reg, 9'h000, dev_reg}, I_WB_DAT, lo_en, hi_en);
      tx_new = merge16(tx_reg, I_WB_DAT, lo_en, hi_en);
      if (wr) begin
         case (idx)
            annp_pkg::IDX_NP_TX: begin
               tx_next = tx_new & annp_pkg::NP_TX_WMASK;
               txwr_next = 1'b1;
            end
            annp_pkg::IDX_IND_CTL: begin
               fn_next = ctl_new[15:14];
               dev_next = ctl_new[4:0];
            end
            annp_pkg::IDX_IND_AD: begin
               if (fn_reg == annp_pkg::FN_ADDR) begin
                  addr_next = merge16(addr_reg, I_WB_DAT, lo_en, hi_en);
               end else begin
                  indwr_next = 1'b1;
                  wdata_next = merge16(I_IND_RDATA, I_WB_DAT, lo_en, hi_en);
               end
            end
            annp_pkg::IDX_INT_MASK: begin
               if (lo_en) begin
                  mask_next = I_WB_DAT[1:0];
               end
            end
            default: begin
               txwr_next = 1'b0;
            end
         endcase
      end
   end

   // Register the writable state.
   always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tx_reg <= annp_pkg::NP_TX_RST;
         fn_reg <= annp_pkg::FN_ADDR;
         dev_reg <= 5'h00;
         addr_reg <= 16'h0000;
         mask_reg <= 2'h0;
         txwr_reg <= 1'b0;
         indwr_reg <= 1'b0;
         wdata_reg <= 16'h0000;
      end else begin
         tx_reg <= tx_next;
         fn_reg <= fn_next;
         dev_reg <= dev_next;
         addr_reg <= addr_next;
         mask_reg <= mask_next;
         txwr_reg <= txwr_next;
         indwr_reg <= indwr_next;
         wdata_reg <= wdata_next;
      end
   end

   // ------------------------------------------------------------
   // Read mux.
   // ------------------------------------------------------------
   logic [15:0] exp_word;
   logic [15:0] rd_word;
   logic [31:0] dat_reg;
   logic [31:0] dat_next;

   // Expansion word: constants, live partner status and latched flags.
   always_comb begin
      exp_word = 16'h0000;
      exp_word[annp_pkg::EXP_NP_LOC_ABLE] = 1'b1;
      exp_word[annp_pkg::EXP_NP_LOC] = 1'b1;
      exp_word[annp_pkg::EXP_PD_FAULT] = exp_flag[1];
      exp_word[annp_pkg::EXP_LP_NP_ABLE] = I_LP_NP_ABLE;
      exp_word[annp_pkg::EXP_NP_ABLE] = 1'b1;
      exp_word[annp_pkg::EXP_PAGE_RX] = exp_flag[0];
      exp_word[annp_pkg::EXP_LP_AN_ABLE] = I_LP_AN_ABLE;
   end

   // Select the read word; unmapped indices read zero.
   always_comb begin
      case (idx)
         annp_pkg::IDX_EXP: rd_word = exp_word;
         annp_pkg::IDX_NP_TX: rd_word = {tx_reg[15:12], I_TX_TOGGLE, tx_reg[10:0]};
         annp_pkg::IDX_NP_RX: rd_word = I_RX_PAGE;
         annp_pkg::IDX_IND_CTL: rd_word = {fn_reg, 9'h000, dev_reg};
         annp_pkg::IDX_IND_AD: rd_word = (fn_reg == annp_pkg::FN_ADDR) ? addr_reg : I_IND_RDATA;
         annp_pkg::IDX_INT_STAT: rd_word = {14'h0000, int_stat};
         annp_pkg::IDX_INT_MASK: rd_word = {14'h0000, mask_reg};
         default: rd_word = 16'h0000;
      endcase
      dat_next = rd ? {16'h0000, rd_word} : dat_reg;
   end

   // Read data register, valid with ack.
   always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         dat_reg <= 32'h0000_0000;
      end else begin
         dat_reg <= dat_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs.
   // ------------------------------------------------------------
   assign O_WB_DAT = dat_reg;
   assign O_TX_PAGE = {tx_reg[15:12], I_TX_TOGGLE, tx_reg[10:0]};
   assign O_TX_PAGE_WR = txwr_reg;
   assign O_IND_DEV = dev_reg;
   assign O_IND_ADDR = addr_reg;
   assign O_IND_WR = indwr_reg;
   assign O_IND_WDATA = wdata_reg;
   // The indirect read pulse is for side effects; data is sampled combinationally.
   assign O_IND_RD = rd && (idx == annp_pkg::IDX_IND_AD) && (fn_reg != annp_pkg::FN_ADDR);
   // Level interrupt while any unmasked status bit stands.
   assign O_IRQ = |(int_stat & mask_reg);
endmodule

// ---- hdl/annp_pkg.sv ----
package annp_pkg;
   // ------------------------------------------------------------
   // Register word indices and the bus address width.
   // ------------------------------------------------------------
   localparam logic [4:0] IDX_EXP = 5'h06;
   localparam logic [4:0] IDX_NP_TX = 5'h07;
   localparam logic [4:0] IDX_NP_RX = 5'h08;
   localparam logic [4:0] IDX_IND_CTL = 5'h0D;
   localparam logic [4:0] IDX_IND_AD = 5'h0E;
   localparam logic [4:0] IDX_INT_STAT = 5'h1A;
   localparam logic [4:0] IDX_INT_MASK = 5'h1B;
   localparam int ADDR_W = 7;
   // ------------------------------------------------------------
   // Autoneg_expansion_status bit positions.
   // ------------------------------------------------------------
   localparam int EXP_LP_AN_ABLE = 0;
   localparam int EXP_PAGE_RX = 1;
   localparam int EXP_NP_ABLE = 2;
   localparam int EXP_LP_NP_ABLE = 3;
   localparam int EXP_PD_FAULT = 4;
   localparam int EXP_NP_LOC = 5;
   localparam int EXP_NP_LOC_ABLE = 6;
   // ------------------------------------------------------------
   // Next page fields and reset values.
   // ------------------------------------------------------------
   localparam int NP_NEXT = 15;
   localparam int NP_ACK = 14;
   localparam int NP_MSG = 13;
   localparam int NP_ACK2 = 12;
   localparam int NP_TOGGLE = 11;
   localparam logic [15:0] NP_TX_RST = 16'h2001;
   localparam logic [15:0] NP_TX_WMASK = 16'hB7FF;
   // ------------------------------------------------------------
   // Indirect access control fields.
   // ------------------------------------------------------------
   localparam logic [1:0] FN_ADDR = 2'h0;
   localparam logic [1:0] FN_DATA = 2'h1;
   localparam logic [4:0] DEV_PCS = 5'h03;
   localparam int DEV_W = 5;
   localparam int INT_W = 2;
endpackage

// ---- hdl/annp_latch.sv ----
`timescale 1ns/1ps
// Sticky flag: an event in the clearing cycle wins over the clear.
module annp_latch #(
   parameter int W = 2
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Set and clear.
   input wire logic [W-1:0] i_set,
   input wire logic i_clr,
   // Flags.
   output logic [W-1:0] o_flag
);
   logic [W-1:0] flag_reg;
   logic [W-1:0] flag_next;

   // Clear first, then let new events set again.
   always_comb begin
      flag_next = (i_clr ? '0 : flag_reg) | i_set;
   end

   // Register the flags.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign o_flag = flag_reg;
endmodule

// ---- hdl/annp_wb_slave.sv ----
`timescale 1ns/1ps
// Classic Wishbone handshake: one wait state, then a single-cycle ack.
module annp_wb_slave (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Bus request.
   input wire logic i_cyc,
   input wire logic i_stb,
   // Handshake outputs.
   output logic o_ack,
   output logic o_fire
);
   logic ack_reg;
   logic ack_next;

   // Ack once per request; the gap cycle stops a second ack while stb stays high.
   always_comb begin
      ack_next = i_cyc && i_stb && !ack_reg;
   end

   // Register the ack.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= ack_next;
      end
   end

   assign o_ack = ack_reg;
   assign o_fire = ack_next;
endmodule

// ---- verif/annp_regs_assertions.sv ----
`timescale 1ns/1ps
// Watches the register bank from its pins only.
module annp_chk (
   // Clock and reset.
   input wire logic I_SYS_CLK,
   input wire logic I_RST_N,
   // Bus.
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [6:0] I_WB_ADR,
   input wire logic [31:0] I_WB_DAT,
   input wire logic [31:0] O_WB_DAT,
   input wire logic O_WB_ACK,
   // Engine side.
   input wire logic I_LP_AN_ABLE,
   input wire logic I_LP_NP_ABLE,
   input wire logic I_PD_FAULT,
   input wire logic I_PAGE_RX,
   input wire logic [15:0] I_RX_PAGE,
   input wire logic [15:0] O_TX_PAGE,
   input wire logic O_TX_PAGE_WR,
   // Indirect space.
   input wire logic O_IND_WR,
   input wire logic O_IND_RD,
   input wire logic [15:0] O_IND_WDATA,
   input wire logic [15:0] I_IND_RDATA
);
   default clocking @(posedge I_SYS_CLK);
   endclocking
   default disable iff (!I_RST_N);
   // The master holds address and direction through the ack cycle.
   logic [4:0] idx;
   logic rd_ack;
   assign idx = I_WB_ADR[6:2];
   assign rd_ack = O_WB_ACK && !I_WB_WE;
   a_ack_latency: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
      else $error("ack late");
   a_exp_fixed: assert property (
      rd_ack && idx == annp_pkg::IDX_EXP |-> (O_WB_DAT & 32'hFFFFFFE4) == 32'h00000064)
      else $error("expansion constant bits wrong");
   a_exp_live: assert property (
      rd_ack && idx == annp_pkg::IDX_EXP |-> O_WB_DAT[0] == $past(I_LP_AN_ABLE)
      && O_WB_DAT[3] == $past(I_LP_NP_ABLE)) else $error("partner ability bits wrong");
   a_latch_set: assert property (
      rd_ack && idx == annp_pkg::IDX_EXP |-> (O_WB_DAT[4] || !$past(I_PD_FAULT, 3))
      && (O_WB_DAT[1] || !$past(I_PAGE_RX, 3))) else $error("latched event lost");
   a_tx_write: assert property (
      O_WB_ACK && I_WB_WE && idx == annp_pkg::IDX_NP_TX |-> O_TX_PAGE_WR
      && ((O_TX_PAGE ^ I_WB_DAT[15:0]) & annp_pkg::NP_TX_WMASK) == 16'h0000)
      else $error("tx page write wrong");
   a_rx_page: assert property (
      rd_ack && idx == annp_pkg::IDX_NP_RX |-> O_WB_DAT == {16'h0000, $past(I_RX_PAGE)})
      else $error("rx page read wrong");
   a_ind_wdata: assert property (
      O_IND_WR |-> O_WB_ACK && I_WB_WE && idx == annp_pkg::IDX_IND_AD
      && O_IND_WDATA == I_WB_DAT[15:0]) else $error("indirect write wrong");
   a_ind_rdata: assert property (
      O_IND_RD |=> O_WB_ACK && O_WB_DAT[15:0] == $past(I_IND_RDATA))
      else $error("indirect read wrong");
endmodule
bind annp_regs annp_chk annp_chk_inst (.I_SYS_CLK, .I_RST_N, .I_WB_CYC, .I_WB_STB,
   .I_WB_WE, .I_WB_ADR, .I_WB_DAT, .O_WB_DAT, .O_WB_ACK, .I_LP_AN_ABLE, .I_LP_NP_ABLE,
   .I_PD_FAULT, .I_PAGE_RX, .I_RX_PAGE, .O_TX_PAGE, .O_TX_PAGE_WR, .O_IND_WR,
   .O_IND_RD, .O_IND_WDATA, .I_IND_RDATA);

// ---- verif/annp_ind_model.sv ----
`timescale 1ns/1ps
// Indirect register space; only 64 slots, enough for the bench.
module annp_ind_model (
   // Clock.
   input wire logic i_clk,
   // Access.
   input wire logic [4:0] i_dev,
   input wire logic [15:0] i_addr,
   input wire logic i_wr,
   input wire logic [15:0] i_wdata,
   output logic [15:0] o_rdata
);
   logic [15:0] mem [0:63];
   logic [5:0] slot;
   assign slot = {i_dev[1:0], i_addr[3:0]};
   assign o_rdata = mem[slot];
   // Store on the one-cycle write strobe.
   always_ff @(posedge i_clk) begin
      if (i_wr) begin
         mem[slot] <= i_wdata;
      end
   end
endmodule

// ---- verif/annp_regs_tb.sv ----
`timescale 1ns/1ps
module annp_regs_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, txwr, iwr, ird, irq;
   logic [6:0] adr = 7'h00;
   logic [31:0] wdat = 32'h00000000, rdat;
   logic lpan = 1'b0, lpnp = 1'b0, pd = 1'b0, prx = 1'b0, tog = 1'b0;
   logic [15:0] rxpg = 16'hA5C3, txpg, iad, iwd, ird_d, v;
   logic [4:0] dev;
   int n_errors = 0;
   int check_count = 0;
   always #4 clk = ~clk;
   annp_regs annp_regs_inst (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc),
      .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'h3), .I_WB_DAT(wdat),
      .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_LP_AN_ABLE(lpan), .I_LP_NP_ABLE(lpnp),
      .I_PD_FAULT(pd), .I_PAGE_RX(prx), .I_RX_PAGE(rxpg), .I_TX_TOGGLE(tog),
      .O_TX_PAGE(txpg), .O_TX_PAGE_WR(txwr), .O_IND_DEV(dev), .O_IND_ADDR(iad),
      .O_IND_WR(iwr), .O_IND_RD(ird), .O_IND_WDATA(iwd), .I_IND_RDATA(ird_d), .O_IRQ(irq));
   annp_ind_model annp_ind_model_inst (.i_clk(clk), .i_dev(dev), .i_addr(iad),
      .i_wr(iwr), .i_wdata(iwd), .o_rdata(ird_d));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // One classic cycle; read data lands in v at the ack edge.
   task automatic bus(input logic w, input logic [4:0] idx, input logic [15:0] d);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {16'h0000, d};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_errors++;
         tally_and_finish();
      end
      v = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic ev(input logic f, input logic p);
      @(posedge clk);
      pd <= f;
      prx <= p;
      @(posedge clk);
      pd <= 1'b0;
      prx <= 1'b0;
   endtask
   task automatic t_reset();
      bus(0, annp_pkg::IDX_EXP, 16'h0000);
      chk("exp", v, 16'h0064);
      bus(0, annp_pkg::IDX_NP_TX, 16'h0000);
      chk("tx", v, 16'h2001);
      bus(0, annp_pkg::IDX_NP_RX, 16'h0000);
      chk("rx", v, 16'hA5C3);
      bus(0, annp_pkg::IDX_IND_CTL, 16'h0000);
      chk("ctl", v, 16'h0000);
      bus(1, 5'h1F, 16'hFFFF);
      bus(0, 5'h1F, 16'h0000);
      chk("unmapped", v, 16'h0000);
      $display("reset done");
   endtask
   task automatic t_exp();
      lpan <= 1'b1;
      lpnp <= 1'b1;
      ev(1, 1);
      bus(0, annp_pkg::IDX_EXP, 16'h0000);
      chk("exp set", v, 16'h007F);
      bus(0, annp_pkg::IDX_EXP, 16'h0000);
      chk("exp clr", v, 16'h006D);
      ev(0, 1);
      bus(0, annp_pkg::IDX_EXP, 16'h0000);
      chk("exp page", v, 16'h006F);
      $display("expansion done");
   endtask
   task automatic t_tx();
      bus(1, annp_pkg::IDX_NP_TX, 16'hFFFF);
      chk("txpg", txpg, 16'hB7FF);
      tog <= 1'b1;
      bus(0, annp_pkg::IDX_NP_TX, 16'h0000);
      chk("tx ones", v, 16'hBFFF);
      bus(1, annp_pkg::IDX_NP_TX, 16'h0000);
      bus(0, annp_pkg::IDX_NP_TX, 16'h0000);
      chk("tx zeros", v, 16'h0800);
      tog <= 1'b0;
      $display("tx page done");
   endtask
   // Address first, then data function, as software must.
   task automatic t_ind();
      bus(1, annp_pkg::IDX_IND_CTL, 16'hFFFF);
      bus(0, annp_pkg::IDX_IND_CTL, 16'h0000);
      chk("ctl", v, 16'hC01F);
      bus(1, annp_pkg::IDX_IND_CTL, {11'h000, annp_pkg::DEV_PCS});
      bus(1, annp_pkg::IDX_IND_AD, 16'h0005);
      bus(0, annp_pkg::IDX_IND_AD, 16'h0000);
      chk("addr", v, 16'h0005);
      bus(1, annp_pkg::IDX_IND_CTL, 16'h4003);
      bus(1, annp_pkg::IDX_IND_AD, 16'h1234);
      bus(1, annp_pkg::IDX_IND_AD, 16'h5678);
      bus(0, annp_pkg::IDX_IND_AD, 16'h0000);
      chk("data", v, 16'h5678);
      chk("iaddr", iad, 16'h0005);
      chk("dev", {11'h000, dev}, 16'h0003);
      bus(1, annp_pkg::IDX_IND_CTL, 16'h8003);
      bus(0, annp_pkg::IDX_IND_AD, 16'h0000);
      chk("data fn2", v, 16'h5678);
      $display("indirect done");
   endtask
   task automatic t_irq();
      // Earlier scenarios left both status bits set; a read clears them first.
      bus(0, annp_pkg::IDX_INT_STAT, 16'h0000);
      chk("stat old", v, 16'h0003);
      bus(1, annp_pkg::IDX_INT_MASK, 16'h0001);
      ev(1, 0);
      @(posedge clk);
      chk("irq masked", {15'h0000, irq}, 16'h0000);
      bus(0, annp_pkg::IDX_INT_STAT, 16'h0000);
      chk("stat", v, 16'h0002);
      ev(0, 1);
      @(posedge clk);
      chk("irq", {15'h0000, irq}, 16'h0001);
      bus(0, annp_pkg::IDX_INT_STAT, 16'h0000);
      chk("stat2", v, 16'h0001);
      chk("irq clr", {15'h0000, irq}, 16'h0000);
      $display("interrupt done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_exp();
      t_tx();
      t_ind();
      t_irq();
      tally_and_finish();
   end
endmodule
